// File: csbu_defs.svh
`ifndef CSBU_DEFS_SVH
`define CSBU_DEFS_SVH

// Program counter width in bits
`define CSBU_PC_W          16

// Bit positions inside the flag register
`define CSBU_FLAG_C        0
`define CSBU_FLAG_Z        1
`define CSBU_FLAG_N        2
`define CSBU_FLAG_V        3
`define CSBU_FLAG_H        5

// Program counter steps in words
`define CSBU_STEP_SEQ      16'h0001
`define CSBU_STEP_SKIP1    16'h0002
`define CSBU_STEP_SKIP2    16'h0003

// Execution cycle counts
`define CSBU_CYC_ONE       2'h1
`define CSBU_CYC_TWO       2'h2
`define CSBU_CYC_THREE     2'h3

// Register byte offsets
`define CSBU_REG_CTRL      4'h0
`define CSBU_REG_STATUS    4'h4
`define CSBU_REG_LASTPC    4'h8
`define CSBU_REG_RETIRED   4'hC

// Control register fields and reset value
`define CSBU_CTRL_EN       0
`define CSBU_CTRL_CLR      1
`define CSBU_CTRL_RST      1'h1

// Bus responses
`define CSBU_RESP_OKAY     2'h0
`define CSBU_RESP_DECERR   2'h3

`endif

// File: csbu_pkg.sv
package csbu_pkg;

    // Decoded flow-control operations
    typedef enum logic [3:0] {
        OP_CMP_IMM         = 4'h0,
        OP_SKIP_REG_ZERO   = 4'h1,
        OP_SKIP_REG_ONE    = 4'h2,
        OP_SKIP_IO_ZERO    = 4'h3,
        OP_SKIP_IO_ONE     = 4'h4,
        OP_BR_FLAG_ONE     = 4'h5,
        OP_BR_FLAG_ZERO    = 4'h6,
        OP_BR_EQUAL        = 4'h7,
        OP_BR_UNEQUAL      = 4'h8,
        OP_BR_CARRY_ONE    = 4'h9,
        OP_BR_CARRY_ZERO   = 4'hA,
        OP_BR_SAME_HIGH    = 4'hB,
        OP_BR_LOWER        = 4'hC,
        OP_BR_NEGATIVE     = 4'hD,
        OP_BR_POSITIVE     = 4'hE,
        OP_NONE            = 4'hF
    } csbu_op_e;

    // Execution states, one-hot
    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_WAIT = 2'b10
    } csbu_state_e;

endpackage

// File: csbu_cmp.sv
`timescale 1ns/1ps
`include "csbu_defs.svh"

module csbu_cmp
    import csbu_pkg::*;
(
    // Operands
    input  wire logic [7:0] rd_val,
    input  wire logic [7:0] imm_val,
    // Flag results
    output logic            c_flag,
    output logic            z_flag,
    output logic            n_flag,
    output logic            v_flag,
    output logic            h_flag
);

    logic [7:0] diff;

    // Subtract without storing, derive the five flags
    always_comb begin
        diff   = rd_val - imm_val;
        z_flag = (diff == 8'h00);
        n_flag = diff[7];
        v_flag = (rd_val[7] & ~imm_val[7] & ~diff[7]) | (~rd_val[7] & imm_val[7] & diff[7]);
        c_flag = (~rd_val[7] & imm_val[7]) | (imm_val[7] & diff[7]) | (diff[7] & ~rd_val[7]);
        h_flag = (~rd_val[3] & imm_val[3]) | (imm_val[3] & diff[3]) | (diff[3] & ~rd_val[3]);
    end

endmodule // csbu_cmp

// File: csbu_core.sv
`timescale 1ns/1ps
`include "csbu_defs.svh"

module csbu_core
    import csbu_pkg::*;
(
    // Clock and reset
    input  wire logic                  aclk,
    input  wire logic                  aresetn,
    // Register bus write channels
    input  wire logic [31:0]           s_axi_awaddr,
    input  wire logic                  s_axi_awvalid,
    output logic                       s_axi_awready,
    input  wire logic [31:0]           s_axi_wdata,
    input  wire logic [3:0]            s_axi_wstrb,
    input  wire logic                  s_axi_wvalid,
    output logic                       s_axi_wready,
    output logic [1:0]                 s_axi_bresp,
    output logic                       s_axi_bvalid,
    input  wire logic                  s_axi_bready,
    // Register bus read channels
    input  wire logic [31:0]           s_axi_araddr,
    input  wire logic                  s_axi_arvalid,
    output logic                       s_axi_arready,
    output logic [31:0]                s_axi_rdata,
    output logic [1:0]                 s_axi_rresp,
    output logic                       s_axi_rvalid,
    input  wire logic                  s_axi_rready,
    // Instruction issue from the core
    input  wire logic                  issue_valid,
    output logic                       issue_ready,
    input  wire csbu_op_e              issue_op,
    input  wire logic [`CSBU_PC_W-1:0] pc_in,
    input  wire logic [7:0]            rd_val,
    input  wire logic [7:0]            imm_val,
    input  wire logic [7:0]            io_val,
    input  wire logic [2:0]            bit_sel,
    input  wire logic [2:0]            flag_sel,
    input  wire logic [6:0]            br_offset,
    input  wire logic                  next_two_word,
    input  wire logic [7:0]            flag_register,
    // Results to the core
    output logic                       done,
    output logic [`CSBU_PC_W-1:0]      pc_out,
    output logic [7:0]                 flags_out,
    output logic                       flags_we
);

    // Execution state
    csbu_state_e              state_ff,     nxt_state;
    logic [1:0]               cnt_ff,       nxt_cnt;
    logic                     done_ff,      nxt_done;
    logic [`CSBU_PC_W-1:0]    pc_ff,        nxt_pc;
    logic [7:0]               flags_ff,     nxt_flags;
    logic                     fwe_ff,       nxt_fwe;
    logic                     taken_ff,     nxt_taken;
    csbu_op_e                 op_ff,        nxt_op;
    logic [31:0]              retired_ff,   nxt_retired;
    logic                     enable_ff,    nxt_enable;
    // Bus state
    logic                     aw_hold_ff,   nxt_aw_hold;
    logic                     w_hold_ff,    nxt_w_hold;
    logic [31:0]              awaddr_ff,    nxt_awaddr;
    logic [31:0]              wdata_ff,     nxt_wdata;
    logic [3:0]               wstrb_ff,     nxt_wstrb;
    logic                     bvalid_ff,    nxt_bvalid;
    logic [1:0]               bresp_ff,     nxt_bresp;
    logic                     rvalid_ff,    nxt_rvalid;
    logic [31:0]              rdata_ff,     nxt_rdata;
    logic [1:0]               rresp_ff,     nxt_rresp;
    // Decode helpers
    logic                     fire;
    logic                     take;
    logic                     is_skip;
    logic                     is_branch;
    logic [1:0]               cyc;
    logic [`CSBU_PC_W-1:0]    disp;
    logic                     c_cmp, z_cmp, n_cmp, v_cmp, h_cmp;

    // Flag arithmetic for the compare
    csbu_cmp u_cmp (
        .rd_val  (rd_val),
        .imm_val (imm_val),
        .c_flag  (c_cmp),
        .z_flag  (z_cmp),
        .n_flag  (n_cmp),
        .v_flag  (v_cmp),
        .h_flag  (h_cmp)
    );

    // Handshake and result outputs
    assign issue_ready   = (state_ff == ST_IDLE) && enable_ff;
    assign fire          = issue_valid && issue_ready;
    assign done          = done_ff;
    assign pc_out        = pc_ff;
    assign flags_out     = flags_ff;
    assign flags_we      = fwe_ff;
    assign s_axi_awready = !aw_hold_ff && !bvalid_ff;
    assign s_axi_wready  = !w_hold_ff && !bvalid_ff;
    assign s_axi_bvalid  = bvalid_ff;
    assign s_axi_bresp   = bresp_ff;
    assign s_axi_arready = !rvalid_ff;
    assign s_axi_rvalid  = rvalid_ff;
    assign s_axi_rdata   = rdata_ff;
    assign s_axi_rresp   = rresp_ff;

    // Condition decode per operation
    always_comb begin
        take      = 1'b0;
        is_skip   = 1'b0;
        is_branch = 1'b0;
        unique case (issue_op)
            OP_SKIP_REG_ZERO: begin is_skip = 1'b1; take = !rd_val[bit_sel]; end
            OP_SKIP_REG_ONE:  begin is_skip = 1'b1; take = rd_val[bit_sel]; end
            OP_SKIP_IO_ZERO:  begin is_skip = 1'b1; take = !io_val[bit_sel]; end
            OP_SKIP_IO_ONE:   begin is_skip = 1'b1; take = io_val[bit_sel]; end
            OP_BR_FLAG_ONE:   begin is_branch = 1'b1; take = flag_register[flag_sel]; end
            OP_BR_FLAG_ZERO:  begin is_branch = 1'b1; take = !flag_register[flag_sel]; end
            OP_BR_EQUAL:      begin is_branch = 1'b1; take = flag_register[`CSBU_FLAG_Z]; end
            OP_BR_UNEQUAL:    begin is_branch = 1'b1; take = !flag_register[`CSBU_FLAG_Z]; end
            OP_BR_CARRY_ONE,
            OP_BR_LOWER:      begin is_branch = 1'b1; take = flag_register[`CSBU_FLAG_C]; end
            OP_BR_CARRY_ZERO,
            OP_BR_SAME_HIGH:  begin is_branch = 1'b1; take = !flag_register[`CSBU_FLAG_C]; end
            OP_BR_NEGATIVE:   begin is_branch = 1'b1; take = flag_register[`CSBU_FLAG_N]; end
            OP_BR_POSITIVE:   begin is_branch = 1'b1; take = !flag_register[`CSBU_FLAG_N]; end
            default:          begin take = 1'b0; end
        endcase
    end

    // Next values of the execution group
    always_comb begin
        disp        = {{(`CSBU_PC_W-7){br_offset[6]}}, br_offset};
        cyc         = `CSBU_CYC_ONE;
        nxt_state   = state_ff;
        nxt_cnt     = cnt_ff;
        nxt_done    = 1'b0;
        nxt_fwe     = 1'b0;
        nxt_pc      = pc_ff;
        nxt_flags   = flags_ff;
        nxt_taken   = taken_ff;
        nxt_op      = op_ff;
        nxt_retired = done_ff ? retired_ff + 32'h0000_0001 : retired_ff;
        if (fire) begin
            nxt_op    = issue_op;
            nxt_taken = take;
            nxt_pc    = pc_in + `CSBU_STEP_SEQ;
            nxt_flags = flag_register;
            if (issue_op == OP_CMP_IMM) begin
                nxt_flags[`CSBU_FLAG_C] = c_cmp;
                nxt_flags[`CSBU_FLAG_Z] = z_cmp;
                nxt_flags[`CSBU_FLAG_N] = n_cmp;
                nxt_flags[`CSBU_FLAG_V] = v_cmp;
                nxt_flags[`CSBU_FLAG_H] = h_cmp;
                nxt_fwe                 = 1'b1;
            end else if (is_skip && take) begin
                nxt_pc = pc_in + (next_two_word ? `CSBU_STEP_SKIP2 : `CSBU_STEP_SKIP1);
                cyc    = next_two_word ? `CSBU_CYC_THREE : `CSBU_CYC_TWO;
            end else if (is_branch && take) begin
                nxt_pc = pc_in + disp + `CSBU_STEP_SEQ;
                cyc    = `CSBU_CYC_TWO;
            end
            if (cyc == `CSBU_CYC_ONE) begin
                nxt_done = 1'b1;
            end else begin
                nxt_state = ST_WAIT;
                nxt_cnt   = cyc - `CSBU_CYC_ONE;
            end
        end else if (state_ff == ST_WAIT) begin
            if (cnt_ff == `CSBU_CYC_ONE) begin
                nxt_done  = 1'b1;
                nxt_state = ST_IDLE;
            end
            nxt_cnt = cnt_ff - `CSBU_CYC_ONE;
        end
    end

    // Register the execution group
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_ff   <= ST_IDLE;
            cnt_ff     <= 2'h0;
            done_ff    <= 1'b0;
            fwe_ff     <= 1'b0;
            pc_ff      <= 16'h0000;
            flags_ff   <= 8'h00;
            taken_ff   <= 1'b0;
            op_ff      <= OP_NONE;
        end else begin
            state_ff   <= nxt_state;
            cnt_ff     <= nxt_cnt;
            done_ff    <= nxt_done;
            fwe_ff     <= nxt_fwe;
            pc_ff      <= nxt_pc;
            flags_ff   <= nxt_flags;
            taken_ff   <= nxt_taken;
            op_ff      <= nxt_op;
        end
    end

    // Next values of the write channel and control register
    always_comb begin
        nxt_aw_hold = aw_hold_ff;
        nxt_w_hold  = w_hold_ff;
        nxt_awaddr  = awaddr_ff;
        nxt_wdata   = wdata_ff;
        nxt_wstrb   = wstrb_ff;
        nxt_bvalid  = bvalid_ff;
        nxt_bresp   = bresp_ff;
        nxt_enable  = enable_ff;
        if (s_axi_awvalid && s_axi_awready) begin
            nxt_aw_hold = 1'b1;
            nxt_awaddr  = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            nxt_w_hold = 1'b1;
            nxt_wdata  = s_axi_wdata;
            nxt_wstrb  = s_axi_wstrb;
        end
        if (aw_hold_ff && w_hold_ff) begin
            nxt_aw_hold = 1'b0;
            nxt_w_hold  = 1'b0;
            nxt_bvalid  = 1'b1;
            nxt_bresp   = `CSBU_RESP_OKAY;
            if (awaddr_ff[31:4] != 28'h000_0000 || awaddr_ff[1:0] != 2'h0) begin
                nxt_bresp = `CSBU_RESP_DECERR;
            end else if (awaddr_ff[3:0] == `CSBU_REG_CTRL) begin
                if (wstrb_ff[0]) begin
                    nxt_enable = wdata_ff[`CSBU_CTRL_EN];
                end
            end else if (awaddr_ff[3:0] != `CSBU_REG_STATUS && awaddr_ff[3:0] != `CSBU_REG_LASTPC
                         && awaddr_ff[3:0] != `CSBU_REG_RETIRED) begin
                nxt_bresp = `CSBU_RESP_DECERR;
            end
        end else if (bvalid_ff && s_axi_bready) begin
            nxt_bvalid = 1'b0;
        end
    end

    // Counter clear strobe from a control write
    logic ctrl_clear;
    assign ctrl_clear = aw_hold_ff && w_hold_ff && wstrb_ff[0] && wdata_ff[`CSBU_CTRL_CLR]
                        && awaddr_ff == 32'h0000_0000;

    // Register the write channel group
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_hold_ff <= 1'b0;
            w_hold_ff  <= 1'b0;
            awaddr_ff  <= 32'h0000_0000;
            wdata_ff   <= 32'h0000_0000;
            wstrb_ff   <= 4'h0;
            bvalid_ff  <= 1'b0;
            bresp_ff   <= 2'h0;
            enable_ff  <= `CSBU_CTRL_RST;
            retired_ff <= 32'h0000_0000;
        end else begin
            aw_hold_ff <= nxt_aw_hold;
            w_hold_ff  <= nxt_w_hold;
            awaddr_ff  <= nxt_awaddr;
            wdata_ff   <= nxt_wdata;
            wstrb_ff   <= nxt_wstrb;
            bvalid_ff  <= nxt_bvalid;
            bresp_ff   <= nxt_bresp;
            enable_ff  <= nxt_enable;
            retired_ff <= ctrl_clear ? 32'h0000_0000 : nxt_retired;
        end
    end

    // Next values of the read channel
    always_comb begin
        nxt_rvalid = rvalid_ff;
        nxt_rdata  = rdata_ff;
        nxt_rresp  = rresp_ff;
        if (s_axi_arvalid && s_axi_arready) begin
            nxt_rvalid = 1'b1;
            nxt_rresp  = `CSBU_RESP_OKAY;
            nxt_rdata  = 32'h0000_0000;
            if (s_axi_araddr[31:4] != 28'h000_0000 || s_axi_araddr[1:0] != 2'h0) begin
                nxt_rresp = `CSBU_RESP_DECERR;
            end else begin
                unique case (s_axi_araddr[3:0])
                    `CSBU_REG_CTRL:    nxt_rdata = {31'h0000_0000, enable_ff};
                    `CSBU_REG_STATUS:  nxt_rdata = {18'h0_0000, op_ff, taken_ff, state_ff == ST_WAIT, flags_ff};
                    `CSBU_REG_LASTPC:  nxt_rdata = {16'h0000, pc_ff};
                    `CSBU_REG_RETIRED: nxt_rdata = retired_ff;
                    default:           nxt_rresp = `CSBU_RESP_DECERR;
                endcase
            end
        end else if (rvalid_ff && s_axi_rready) begin
            nxt_rvalid = 1'b0;
        end
    end

    // Register the read channel
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_ff <= 1'b0;
            rdata_ff  <= 32'h0000_0000;
            rresp_ff  <= 2'h0;
        end else begin
            rvalid_ff <= nxt_rvalid;
            rdata_ff  <= nxt_rdata;
            rresp_ff  <= nxt_rresp;
        end
    end

    // Checks on execution timing and targets
    cmp_one_cycle_a: assert property (@(posedge aclk) disable iff (!aresetn)
        fire && issue_op == OP_CMP_IMM |=> done && flags_we
            && flags_out[`CSBU_FLAG_Z] == ($past(rd_val) == $past(imm_val)))
        else $error("compare result or timing wrong");
    flags_kept_a: assert property (@(posedge aclk) disable iff (!aresetn)
        flags_we |-> op_ff == OP_CMP_IMM)
        else $error("flags written by a non-compare");
    skip_short_a: assert property (@(posedge aclk) disable iff (!aresetn)
        fire && issue_op == OP_SKIP_REG_ONE && rd_val[bit_sel] && !next_two_word
        |=> !done ##1 done && pc_out == $past(pc_in, 2) + 16'h0002)
        else $error("short skip target or timing wrong");
    skip_long_a: assert property (@(posedge aclk) disable iff (!aresetn)
        fire && issue_op == OP_SKIP_IO_ZERO && !io_val[bit_sel] && next_two_word
        |-> ##3 done && pc_out == $past(pc_in, 3) + 16'h0003)
        else $error("long skip target or timing wrong");
    skip_miss_a: assert property (@(posedge aclk) disable iff (!aresetn)
        fire && issue_op == OP_SKIP_IO_ONE && !io_val[bit_sel]
        |=> done && pc_out == $past(pc_in) + 16'h0001)
        else $error("untaken skip wrong");
    branch_taken_a: assert property (@(posedge aclk) disable iff (!aresetn)
        fire && issue_op == OP_BR_FLAG_ONE && flag_register[flag_sel]
        |-> ##2 done && $past(done) == 1'b0
            && pc_out == $past(pc_in, 2) + {{9{$past(br_offset[6], 2)}}, $past(br_offset, 2)} + 16'h0001)
        else $error("taken branch target wrong");
    branch_miss_a: assert property (@(posedge aclk) disable iff (!aresetn)
        fire && issue_op == OP_BR_EQUAL && !flag_register[`CSBU_FLAG_Z]
        |=> done && pc_out == $past(pc_in) + 16'h0001)
        else $error("untaken branch wrong");
    carry_branch_a: assert property (@(posedge aclk) disable iff (!aresetn)
        fire && issue_op == OP_BR_LOWER |=> taken_ff == $past(flag_register[`CSBU_FLAG_C]))
        else $error("lower branch condition wrong");
    sign_branch_a: assert property (@(posedge aclk) disable iff (!aresetn)
        fire && issue_op == OP_BR_POSITIVE |=> taken_ff == !$past(flag_register[`CSBU_FLAG_N]))
        else $error("positive branch condition wrong");

endmodule // csbu_core

// File: tb_compare_skip_branch_unit.sv
`timescale 1ns/1ps
`include "csbu_defs.svh"

module tb_compare_skip_branch_unit
    import csbu_pkg::*;
;
    // Clock, reset and bus
    logic        aclk, aresetn;
    logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic        s_axi_rvalid, s_axi_rready;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    // Issue and results
    logic        issue_valid, issue_ready, next_two_word, done, flags_we;
    csbu_op_e    issue_op;
    logic [15:0] pc_in, pc_out, last_pc;
    logic [7:0]  rd_val, imm_val, io_val, flag_register, flags_out;
    logic [2:0]  bit_sel, flag_sel;
    logic [6:0]  br_offset;
    logic [31:0] last_st, retired;
    int          miscompares, num_checks;

    csbu_core dut_u (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .issue_valid(issue_valid),
        .issue_ready(issue_ready), .issue_op(issue_op), .pc_in(pc_in), .rd_val(rd_val), .imm_val(imm_val),
        .io_val(io_val), .bit_sel(bit_sel), .flag_sel(flag_sel), .br_offset(br_offset),
        .next_two_word(next_two_word), .flag_register(flag_register), .done(done), .pc_out(pc_out),
        .flags_out(flags_out), .flags_we(flags_we));

    // Clock generator
    always #5 aclk = ~aclk;

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic finish_test();
        $display("checks %0d miscompares %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask

    // Register write, both channels offered together
    task automatic axi_wr(input logic [31:0] a, input logic [31:0] d, input logic [1:0] er);
        logic aw_p, w_p, aw_g, w_g;
        aw_p = 1'b1;
        w_p = 1'b1;
        @(posedge aclk);
        s_axi_awaddr  <= a;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata   <= d;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        while (aw_p || w_p) begin
            @(negedge aclk);
            aw_g = aw_p && s_axi_awready;
            w_g = w_p && s_axi_wready;
            @(posedge aclk);
            if (aw_g) s_axi_awvalid <= 1'b0;
            if (w_g) s_axi_wvalid <= 1'b0;
            aw_p = aw_p && !aw_g;
            w_p = w_p && !w_g;
        end
        do begin @(negedge aclk); end while (s_axi_bvalid !== 1'b1);
        check("bresp", s_axi_bresp, er);
        @(posedge aclk);
        s_axi_bready <= 1'b0;
    endtask

    // Register read and compare
    task automatic axi_rd(input logic [31:0] a, input logic [31:0] ed, input logic [1:0] er);
        @(posedge aclk);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        do begin @(negedge aclk); end while (s_axi_arready !== 1'b1);
        @(posedge aclk);
        s_axi_arvalid <= 1'b0;
        do begin @(negedge aclk); end while (s_axi_rvalid !== 1'b1);
        check("rdata", s_axi_rdata, ed);
        check("rresp", s_axi_rresp, er);
        @(posedge aclk);
        s_axi_rready <= 1'b0;
    endtask

    // One instruction: issue, count cycles to done, judge results
    task automatic run_op(input csbu_op_e op, input logic [15:0] pc, input logic [7:0] fl, input logic [7:0] rv,
                          input logic [7:0] iv, input logic [7:0] k, input logic [6:0] off, input logic two,
                          input logic [15:0] epc, input logic [7:0] efl, input int ecyc);
        int n;
        n = 0;
        @(posedge aclk);
        issue_valid   <= 1'b1;
        issue_op      <= op;
        pc_in         <= pc;
        flag_register <= fl;
        rd_val        <= rv;
        io_val        <= iv;
        imm_val       <= k;
        br_offset     <= off;
        next_two_word <= two;
        do begin @(negedge aclk); n++; end while (issue_ready !== 1'b1 && n < 20);
        @(posedge aclk);
        issue_valid <= 1'b0;
        n = 0;
        do begin
            @(negedge aclk);
            n++;
            if (n == 1) check("issue_ready busy", issue_ready, ecyc == 1);
        end while (done !== 1'b1 && n < 8);
        retired++;
        last_pc = epc;
        last_st = {18'h0, op, ecyc > 1, 1'b0, efl};
        check("cycles", n, ecyc);
        check("pc_out", pc_out, epc);
        check("flags_out", flags_out, efl);
        check("flags_we", flags_we, op == OP_CMP_IMM);
    endtask

    // Compare against a table of borrow, overflow and zero cases
    task automatic test_compare();
        logic [7:0] d, k, r, e;
        for (int i = 0; i < 4; i++) begin
            d = (i == 0) ? 8'h00 : (i == 1) ? 8'h10 : (i == 2) ? 8'h80 : 8'h01;
            k = (i == 0) ? 8'h00 : (i == 3) ? 8'h02 : 8'h01;
            r = d - k;
            e = i[0] ? 8'hFF : 8'h00;
            e[`CSBU_FLAG_C] = d < k;
            e[`CSBU_FLAG_Z] = r == 8'h00;
            e[`CSBU_FLAG_N] = r[7];
            e[`CSBU_FLAG_V] = (d[7] != k[7]) && (r[7] != d[7]);
            e[`CSBU_FLAG_H] = d[3:0] < k[3:0];
            run_op(OP_CMP_IMM, 16'h0200, i[0] ? 8'hFF : 8'h00, d, ~d, k, 7'h00, 1'b0, 16'h0201, e, 1);
        end
    endtask

    // All four skips, bit clear and set, one- and two-word follower
    task automatic test_skips();
        csbu_op_e   op;
        logic       one, hit, io;
        logic [7:0] v;
        logic [15:0] st;
        logic [2:0] s;
        for (int i = 0; i < 16; i++) begin
            op = csbu_op_e'(4'h1 + i[3:2]);
            s = i[3:1];
            v = i[0] ? (8'h01 << s) : ~(8'h01 << s);
            @(posedge aclk);
            bit_sel <= s;
            one = op inside {OP_SKIP_REG_ONE, OP_SKIP_IO_ONE};
            io = op inside {OP_SKIP_IO_ZERO, OP_SKIP_IO_ONE};
            hit = i[0] == one;
            st = hit ? (i[1] ? 16'h0003 : 16'h0002) : 16'h0001;
            run_op(op, 16'hFFFE, 8'hA5, io ? ~v : v, io ? v : ~v, 8'h00, 7'h00, i[1],
                   16'hFFFE + st, 8'hA5, int'(st));
        end
    endtask

    // Every branch, flag one and zero, offsets at both extremes
    task automatic test_branches();
        csbu_op_e   op;
        logic       hit;
        logic [7:0] fl;
        logic [6:0] off;
        int         b;
        logic [2:0] fs;
        for (int i = 0; i < 20; i++) begin
            op = csbu_op_e'(4'h5 + i[4:1]);
            fs = 3'(i + 3);
            @(posedge aclk);
            flag_sel <= fs;
            b = op inside {OP_BR_FLAG_ONE, OP_BR_FLAG_ZERO} ? int'(fs) : op inside {OP_BR_EQUAL, OP_BR_UNEQUAL} ?
                `CSBU_FLAG_Z : op inside {OP_BR_NEGATIVE, OP_BR_POSITIVE} ? `CSBU_FLAG_N : `CSBU_FLAG_C;
            fl = i[0] ? (8'h01 << b) : ~(8'h01 << b);
            hit = i[0] == (op inside {OP_BR_FLAG_ONE, OP_BR_EQUAL, OP_BR_CARRY_ONE, OP_BR_LOWER, OP_BR_NEGATIVE});
            off = i[1] ? 7'h40 : 7'h3F;
            run_op(op, 16'h0010, fl, 8'h00, 8'h00, 8'h00, off, 1'b0,
                   hit ? 16'h0011 + {{9{off[6]}}, off} : 16'h0011, fl,
                   hit ? 2 : 1);
        end
    endtask

    // Register map, read-only, clear, enable gating and unmapped address
    task automatic test_regs();
        axi_rd({28'h0, `CSBU_REG_STATUS}, last_st, `CSBU_RESP_OKAY);
        axi_rd({28'h0, `CSBU_REG_RETIRED}, retired, `CSBU_RESP_OKAY);
        axi_wr({28'h0, `CSBU_REG_LASTPC}, 32'hFFFF_FFFF, `CSBU_RESP_OKAY);
        axi_rd({28'h0, `CSBU_REG_LASTPC}, {16'h0, last_pc}, `CSBU_RESP_OKAY);
        axi_wr({28'h0, `CSBU_REG_CTRL}, 32'h0000_0003, `CSBU_RESP_OKAY);
        axi_rd({28'h0, `CSBU_REG_RETIRED}, 32'h0000_0000, `CSBU_RESP_OKAY);
        axi_wr({28'h0, `CSBU_REG_CTRL}, 32'h0000_0000, `CSBU_RESP_OKAY);
        @(negedge aclk);
        check("issue_ready off", issue_ready, 1'b0);
        axi_wr({28'h0, `CSBU_REG_CTRL}, 32'h0000_0001, `CSBU_RESP_OKAY);
        @(negedge aclk);
        check("issue_ready on", issue_ready, 1'b1);
        axi_rd(32'h0000_0010, 32'h0000_0000, `CSBU_RESP_DECERR);
        axi_wr(32'h0000_0010, 32'h0000_0000, `CSBU_RESP_DECERR);
    endtask

    // Watchdog
    initial begin
        #200000;
        miscompares++;
        finish_test();
    end

    // Main sequence
    initial begin
        {aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        {s_axi_awaddr, s_axi_wdata, s_axi_araddr, pc_in, rd_val, imm_val, io_val, flag_register} = '0;
        {issue_valid, next_two_word, br_offset, retired, last_pc, last_st} = '0;
        {miscompares, num_checks} = '0;
        issue_op = OP_NONE;
        bit_sel = 3'h7;
        flag_sel = 3'h6;
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        axi_rd({28'h0, `CSBU_REG_CTRL}, 32'h0000_0001, `CSBU_RESP_OKAY);
        test_compare();
        test_skips();
        test_branches();
        test_regs();
        finish_test();
    end
endmodule // tb_compare_skip_branch_unit
